// [inc/boot_select_consts.vh]
/*
  constants for the reset-time boot-mode selector: strap patterns,
  register offsets and presets, signature addresses and bit positions.
  assumes inclusion by bare name from the design files.
*/
`ifndef BOOT_SELECT_CONSTS_VH
`define BOOT_SELECT_CONSTS_VH

// strap patterns on port-0 bits 5:4
`define PAT_NORMAL 2'h3
`define PAT_STD_BOOT 2'h2
`define PAT_ALT_BOOT 2'h1
`define STRAP_HI 5
`define STRAP_LO 4
// other port-0 fields used for presets
`define P0_HIGH_BYTE_DISABLE_BIT 7
`define P0_BUS_TYPE_FIELD_HI 7
`define P0_BUS_TYPE_FIELD_LO 6

// bus register byte offsets (printed offset is a multiple of four? no:
// 0xFE0A is not, so it is kept as an index, byte address = 4 * index)
`define IDX_EMU_STATUS 16'hFE0A
`define ADDR_EMU_STATUS 18'h3F828
`define ADDR_SYS_CONFIG 18'h00000
`define ADDR_EXT_SELECT 18'h00004
`define ADDR_BUS_CONFIG0 18'h00008
`define ADDR_BOOT_STATUS 18'h0000C
`define ADDR_CONTROL 18'h00010

// emulation status bits
`define EMU_ALT_BIT 5
// system configuration presets and bits
`define SYS_CFG_ALT 16'h0404
`define SYS_CFG_RESET 16'h0000
`define SYS_INTERNAL_ROM_ENABLE_BIT 10
`define SYS_HIGH_BYTE_DISABLE_BIT 9
`define SYS_EXT_PERIPH_ENABLE_BIT 2
// extension peripheral select preset
`define EXT_SEL_ALT 16'h002D
`define EXT_SEL_RESET 16'h0000
// bus configuration 0
`define BUSCFG_OFF 16'h0000
`define BUSCFG_ACT_BIT 10
`define BUSCFG_ALE_BIT 9
`define BUSCFG_TYP_HI 7
`define BUSCFG_TYP_LO 6

// signature check word addresses (24-bit word addresses as printed)
`define SIG_USER_OP0 24'h000000
`define SIG_USER_OP1 24'h001FFC
`define SIG_USER_REF 24'h001FFE
`define SIG_ALT_OP0 24'h090000
`define SIG_ALT_OP1 24'h091FFC
`define SIG_ALT_REF 24'h091FFE
// entry points
`define ENTRY_ALT 24'h090000
`define ENTRY_TEST_FLASH 24'h000000

// outcome codes
`define OUT_NONE 3'h0
`define OUT_NORMAL 3'h1
`define OUT_STD_BOOT 3'h2
`define OUT_ALT_USER 3'h3
`define OUT_ALT_ALT 3'h4
`define OUT_TEST 3'h5

// control register bits
`define CTL_END_OF_INIT_INSTRUCTION_BIT 0
`define CTL_WDT_RST_BIT 1
`define CTL_SW_RST_BIT 2

`endif

// [logic/signature_check.v]
/*
  signature arithmetic for one check: add two flash words, complement the
  low byte of the sum, compare with the reference word.
  assumes the three words are stable while match is used.
*/
`timescale 1ns/1ps
`default_nettype none
module signature_check #(
  parameter WIDTH = 16
) (
  // operands
  input wire [WIDTH-1:0] op0,
  input wire [WIDTH-1:0] op1,
  input wire [WIDTH-1:0] ref_word,
  // result
  output wire match
);
  // 16-bit sum, carry dropped as the core adder does
  wire [WIDTH-1:0] sum;
  // sum with low byte complemented
  wire [WIDTH-1:0] folded;

  assign sum = op0 + op1;
  assign folded = {sum[WIDTH-1:8], ~sum[7:0]};
  assign match = (folded == ref_word);
endmodule
`default_nettype wire

// [logic/alternate_boot_mode_select.v]
/*
  reset-time boot-mode selector: latches the port-0 straps at reset
  release, decodes the boot outcome, runs the signature checks through a
  flash read port, presets configuration registers and exposes them on an
  ahb-lite slave.
  assumes hclk runs before and after hresetn rises, straps are stable at
  release, and flash reads answer with a one-cycle valid pulse.
*/
//
// Notes on behaviour
// - straps 5:4 latched at release; 01 alternate
// - pattern 11 gives ordinary reset sequence
// - pattern 10 standard loader; alt indicator cleared
// - alternate pattern runs signature check, picks sequence
// - other patterns select internal test mode
// - user check: words 000000, 001FFC vs 001FFE
// - alternate check: words 090000, 091FFC vs 091FFE
// - low byte complemented, exact match passes
// - status bit 5 shows alternate selection, sticky
// - watchdog off; watchdog reset becomes software reset
// - alternate mode left only by reset
// - presets 0404 system config, 002D peripheral select
// - boot modes force rom enable, strap byte-disable
// - external access pin picks bus configuration 0
// - primary flash refuses fetches; extension flash allows
// - vectors and test flash stay at zero
// - alternate pass starts code at 090000
// - select and enable writable until end of init
// - no signature match falls back to loader
`timescale 1ns/1ps
`default_nettype none
`include "boot_select_consts.vh"
module alternate_boot_mode_select #(
  parameter AW = 24,
  parameter DW = 16
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // board straps and pins
  input wire [7:0] port0_low_config_pins,
  input wire external_access_pin,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // flash read port for the signature checks
  output reg flash_rd,
  output reg [AW-1:0] flash_addr,
  input wire [DW-1:0] flash_rdata,
  input wire flash_rvalid,
  // core-side events
  input wire watchdog_reset_req,
  input wire ifetch_req,
  input wire ifetch_in_xflash,
  // outcome to the core
  output reg [2:0] boot_outcome,
  output reg boot_done,
  output reg [AW-1:0] start_addr,
  output reg watchdog_enable,
  output reg sw_reset_req,
  output reg fetch_refused,
  output reg ext_flash_enable,
  output reg vector_at_zero
);
  // strap synchroniser, three stages
  reg [7:0] p0_s1_q, p0_s2_q, p0_s3_q;
  reg ea_s1_q, ea_s2_q, ea_s3_q;
  // one bit per stage that already holds a pin sample since release;
  // without it the cleared stages agree and zeros would be latched
  reg [2:0] sync_fill_q;
  // latched straps and the one-shot capture flag
  reg [7:0] p0_cap_q;
  reg ea_cap_q;
  reg captured_q;
  // registers
  reg [15:0] emu_status_q;
  reg [15:0] sys_cfg_q;
  reg [15:0] ext_sel_q;
  reg [15:0] bus_cfg0_q;
  reg end_of_init_instruction_done_q;
  reg alt_mode_q;
  // check sequencer
  localparam [3:0] S_CAPTURE = 4'h0;
  localparam [3:0] S_DECODE = 4'h1;
  localparam [3:0] S_RD = 4'h2;
  localparam [3:0] S_WAIT = 4'h3;
  localparam [3:0] S_EVAL = 4'h4;
  localparam [3:0] S_DONE = 4'h5;
  reg [3:0] state_q;
  reg [1:0] word_q; // which of three words
  reg pass_q; // 0 user check, 1 alternate check
  reg [15:0] op0_q, op1_q, ref_q;
  wire sig_match;
  // bus data-phase capture
  reg wr_pend_q;
  reg [17:0] wr_addr_q;

  signature_check #(.WIDTH(16)) u_sig (
    .op0(op0_q),
    .op1(op1_q),
    .ref_word(ref_q),
    .match(sig_match)
  );

  // address of the word the sequencer wants next
  reg [AW-1:0] next_addr;
  always @* begin
    next_addr = `SIG_USER_OP0;
    case ({pass_q, word_q})
      3'h0: next_addr = `SIG_USER_OP0;
      3'h1: next_addr = `SIG_USER_OP1;
      3'h2: next_addr = `SIG_USER_REF;
      3'h4: next_addr = `SIG_ALT_OP0;
      3'h5: next_addr = `SIG_ALT_OP1;
      3'h6: next_addr = `SIG_ALT_REF;
      default: next_addr = `SIG_USER_OP0;
    endcase
  end

  // strap synchronisers; compare only stages two and three
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p0_s1_q <= 8'h00;
      p0_s2_q <= 8'h00;
      p0_s3_q <= 8'h00;
      ea_s1_q <= 1'h0;
      ea_s2_q <= 1'h0;
      ea_s3_q <= 1'h0;
      sync_fill_q <= 3'h0;
    end else begin
      sync_fill_q <= {sync_fill_q[1:0], 1'h1};
      p0_s1_q <= port0_low_config_pins;
      p0_s2_q <= p0_s1_q;
      p0_s3_q <= p0_s2_q;
      ea_s1_q <= external_access_pin;
      ea_s2_q <= ea_s1_q;
      ea_s3_q <= ea_s2_q;
    end
  end

  // main sequencer and configuration registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= S_CAPTURE;
      captured_q <= 1'h0;
      p0_cap_q <= 8'h00;
      ea_cap_q <= 1'h0;
      word_q <= 2'h0;
      pass_q <= 1'h0;
      op0_q <= 16'h0000;
      op1_q <= 16'h0000;
      ref_q <= 16'h0000;
      emu_status_q <= 16'h0000;
      sys_cfg_q <= `SYS_CFG_RESET;
      ext_sel_q <= `EXT_SEL_RESET;
      bus_cfg0_q <= `BUSCFG_OFF;
      end_of_init_instruction_done_q <= 1'h0;
      alt_mode_q <= 1'h0;
      flash_rd <= 1'h0;
      flash_addr <= {AW{1'b0}};
      boot_outcome <= `OUT_NONE;
      boot_done <= 1'h0;
      start_addr <= `ENTRY_TEST_FLASH;
      watchdog_enable <= 1'h0;
      sw_reset_req <= 1'h0;
      fetch_refused <= 1'h0;
      ext_flash_enable <= 1'h0;
      vector_at_zero <= 1'h1;
    end else begin
      flash_rd <= 1'h0;
      sw_reset_req <= 1'h0;
      fetch_refused <= 1'h0;
      case (state_q)
        // wait for settled straps, take them once
        S_CAPTURE: begin
          if (!captured_q && sync_fill_q[2] && p0_s2_q == p0_s3_q &&
              ea_s2_q == ea_s3_q) begin
            p0_cap_q <= p0_s3_q;
            ea_cap_q <= ea_s3_q;
            captured_q <= 1'h1;
            state_q <= S_DECODE;
          end
        end
        // decode the strap pattern
        S_DECODE: begin
          // bus configuration 0 from external access strap
          if (ea_cap_q) begin
            bus_cfg0_q <= `BUSCFG_OFF;
          end else begin
            bus_cfg0_q <= 16'h0000;
            bus_cfg0_q[`BUSCFG_ACT_BIT] <= 1'h1;
            bus_cfg0_q[`BUSCFG_ALE_BIT] <= 1'h1;
            bus_cfg0_q[`BUSCFG_TYP_HI:`BUSCFG_TYP_LO] <=
              p0_cap_q[`P0_BUS_TYPE_FIELD_HI:`P0_BUS_TYPE_FIELD_LO];
          end
          case (p0_cap_q[`STRAP_HI:`STRAP_LO])
            `PAT_NORMAL: begin
              boot_outcome <= `OUT_NORMAL;
              watchdog_enable <= 1'h1;
              boot_done <= 1'h1;
              state_q <= S_DONE;
            end
            `PAT_STD_BOOT: begin
              boot_outcome <= `OUT_STD_BOOT;
              emu_status_q[`EMU_ALT_BIT] <= 1'h0;
              sys_cfg_q[`SYS_INTERNAL_ROM_ENABLE_BIT] <= 1'h1;
              sys_cfg_q[`SYS_HIGH_BYTE_DISABLE_BIT] <=
                p0_cap_q[`P0_HIGH_BYTE_DISABLE_BIT];
              start_addr <= `ENTRY_TEST_FLASH;
              boot_done <= 1'h1;
              state_q <= S_DONE;
            end
            `PAT_ALT_BOOT: begin
              emu_status_q[`EMU_ALT_BIT] <= 1'h1;
              alt_mode_q <= 1'h1;
              sys_cfg_q <= `SYS_CFG_ALT;
              sys_cfg_q[`SYS_HIGH_BYTE_DISABLE_BIT] <=
                p0_cap_q[`P0_HIGH_BYTE_DISABLE_BIT];
              ext_sel_q <= `EXT_SEL_ALT;
              pass_q <= 1'h1; // alternate signature first
              word_q <= 2'h0;
              state_q <= S_RD;
            end
            default: begin
              boot_outcome <= `OUT_TEST;
              boot_done <= 1'h1;
              state_q <= S_DONE;
            end
          endcase
        end
        // issue one flash read
        S_RD: begin
          flash_rd <= 1'h1;
          flash_addr <= next_addr;
          state_q <= S_WAIT;
        end
        // collect the word
        S_WAIT: begin
          if (flash_rvalid) begin
            case (word_q)
              2'h0: op0_q <= flash_rdata;
              2'h1: op1_q <= flash_rdata;
              default: ref_q <= flash_rdata;
            endcase
            if (word_q == 2'h2) begin
              state_q <= S_EVAL;
            end else begin
              word_q <= word_q + 2'h1;
              state_q <= S_RD;
            end
          end
        end
        // judge the signature
        S_EVAL: begin
          if (sig_match) begin
            boot_outcome <= pass_q ? `OUT_ALT_ALT : `OUT_ALT_USER;
            start_addr <= pass_q ? `ENTRY_ALT : `ENTRY_TEST_FLASH;
            boot_done <= 1'h1;
            state_q <= S_DONE;
          end else if (pass_q) begin
            pass_q <= 1'h0; // try the user signature
            word_q <= 2'h0;
            state_q <= S_RD;
          end else begin
            boot_outcome <= `OUT_STD_BOOT;
            start_addr <= `ENTRY_TEST_FLASH;
            boot_done <= 1'h1;
            state_q <= S_DONE;
          end
        end
        // stay here until reset; the only way out
        S_DONE: begin
          state_q <= S_DONE;
        end
        default: begin
          state_q <= S_DONE;
        end
      endcase
      // bootstrap paths keep the watchdog off
      if (alt_mode_q || boot_outcome == `OUT_STD_BOOT) begin
        watchdog_enable <= 1'h0;
      end
      // a watchdog reset in alternate mode becomes a software reset
      if (alt_mode_q && watchdog_reset_req) begin
        sw_reset_req <= 1'h1;
      end
      // instruction fetch from primary flash is refused
      if (ifetch_req && !ifetch_in_xflash) begin
        fetch_refused <= 1'h1;
      end
      ext_flash_enable <= sys_cfg_q[`SYS_EXT_PERIPH_ENABLE_BIT] && ext_sel_q != 16'h0;
      vector_at_zero <= 1'h1;
      // bus write data phase
      if (wr_pend_q) begin
        case (wr_addr_q)
          `ADDR_SYS_CONFIG: begin
            if (!end_of_init_instruction_done_q) begin
              sys_cfg_q[`SYS_EXT_PERIPH_ENABLE_BIT] <= hwdata[`SYS_EXT_PERIPH_ENABLE_BIT];
            end
          end
          `ADDR_EXT_SELECT: begin
            if (!end_of_init_instruction_done_q) begin
              ext_sel_q <= hwdata[15:0];
            end
          end
          `ADDR_CONTROL: begin
            if (hwdata[`CTL_END_OF_INIT_INSTRUCTION_BIT]) begin
              end_of_init_instruction_done_q <= 1'h1;
            end
            if (hwdata[`CTL_SW_RST_BIT]) begin
              sw_reset_req <= 1'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ahb-lite slave: zero wait states, always okay
  wire take = hsel && hready && htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'h0;
      wr_addr_q <= 18'h00000;
      hrdata <= 32'h00000000;
      hreadyout <= 1'h1;
      hresp <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      wr_pend_q <= take && hwrite;
      wr_addr_q <= haddr[17:0];
      if (take && !hwrite) begin
        case (haddr[17:0])
          `ADDR_EMU_STATUS: hrdata <= {16'h0000, emu_status_q};
          `ADDR_SYS_CONFIG: hrdata <= {16'h0000, sys_cfg_q};
          `ADDR_EXT_SELECT: hrdata <= {16'h0000, ext_sel_q};
          `ADDR_BUS_CONFIG0: hrdata <= {16'h0000, bus_cfg0_q};
          `ADDR_BOOT_STATUS: hrdata <= {24'h000000, end_of_init_instruction_done_q,
            alt_mode_q, state_q[1:0], boot_done, boot_outcome};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [sim/boot_sel_chk.sv]
/*
  checker for the boot-mode selector: timing relations between the
  straps outcome, the core-side events and the flash read port.
  assumes it is bound to the selector top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "boot_select_consts.vh"
module boot_sel_chk #(
  parameter AW = 24
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // flash read port
  input wire logic flash_rd,
  input wire logic [AW-1:0] flash_addr,
  // core-side events
  input wire logic watchdog_reset_req,
  input wire logic ifetch_req,
  input wire logic ifetch_in_xflash,
  // outcome
  input wire logic [2:0] boot_outcome,
  input wire logic boot_done,
  input wire logic [AW-1:0] start_addr,
  input wire logic watchdog_enable,
  input wire logic sw_reset_req,
  input wire logic fetch_refused,
  input wire logic vector_at_zero
);
  // one domain: clock and reset given once
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // alternate outcome seen by several checks
  wire alt_w = boot_outcome == `OUT_ALT_ALT || boot_outcome == `OUT_ALT_USER;

  property p_vec;
    vector_at_zero;
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector table left address zero");
  property p_wdt_alt;
    alt_w |-> !watchdog_enable;
  endproperty
  a_wdt_alt: assert property (p_wdt_alt)
    else $error("watchdog enabled in alternate mode");
  property p_wdt_sw;
    alt_w && watchdog_reset_req |-> ##[1:2] sw_reset_req;
  endproperty
  a_wdt_sw: assert property (p_wdt_sw)
    else $error("watchdog reset not turned into software reset");
  property p_wdt_norm;
    boot_outcome == `OUT_NORMAL |-> watchdog_enable;
  endproperty
  a_wdt_norm: assert property (p_wdt_norm)
    else $error("watchdog off in normal operation");
  property p_fetch;
    ifetch_req && !ifetch_in_xflash |-> ##[1:2] fetch_refused;
  endproperty
  a_fetch: assert property (p_fetch)
    else $error("fetch from primary flash not refused");
  property p_refuse_cause;
    fetch_refused |-> ($past(ifetch_req) && !$past(ifetch_in_xflash)) ||
      ($past(ifetch_req, 2) && !$past(ifetch_in_xflash, 2));
  endproperty
  a_refuse_cause: assert property (p_refuse_cause)
    else $error("fetch refused without a primary flash fetch");
  property p_start;
    boot_outcome == `OUT_ALT_ALT |-> start_addr == `ENTRY_ALT;
  endproperty
  a_start: assert property (p_start)
    else $error("alternate entry address wrong");
  property p_done_hold;
    boot_done |=> boot_done && $stable(boot_outcome);
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("boot outcome changed without reset");
  property p_no_resample;
    boot_done |-> !flash_rd;
  endproperty
  a_no_resample: assert property (p_no_resample)
    else $error("flash read after boot decided");
  property p_sig_addr;
    flash_rd |-> flash_addr inside {`SIG_ALT_OP0, `SIG_ALT_OP1, `SIG_ALT_REF,
      `SIG_USER_OP0, `SIG_USER_OP1, `SIG_USER_REF};
  endproperty
  a_sig_addr: assert property (p_sig_addr)
    else $error("flash read outside signature words");
endmodule
bind alternate_boot_mode_select boot_sel_chk #(.AW(AW)) chk_u (
  .hclk, .hresetn, .flash_rd, .flash_addr, .watchdog_reset_req,
  .ifetch_req, .ifetch_in_xflash, .boot_outcome, .boot_done, .start_addr,
  .watchdog_enable, .sw_reset_req, .fetch_refused, .vector_at_zero);
`default_nettype wire

// [sim/flash_model.sv]
/*
  flash read partner: answers each read with a valid pulse after a
  latency that rotates from prompt to slow.
  assumes the bench preloads mem with the six signature words.
*/
`timescale 1ns/1ps
`default_nettype none
`include "boot_select_consts.vh"
module flash_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // read port
  input wire logic flash_rd,
  input wire logic [23:0] flash_addr,
  output logic [15:0] flash_rdata,
  output logic flash_rvalid
);
  logic [15:0] mem [0:5]; // alt op0, op1, ref, user op0, op1, ref
  logic [23:0] addr_q; // address being served
  logic busy_q; // a read is pending
  logic [1:0] cnt_q; // cycles left
  logic [1:0] lat_q; // next latency
  // word lookup by flash word address
  function automatic logic [15:0] word(input logic [23:0] a);
    case (a)
      `SIG_ALT_OP0: word = mem[0];
      `SIG_ALT_OP1: word = mem[1];
      `SIG_ALT_REF: word = mem[2];
      `SIG_USER_OP0: word = mem[3];
      `SIG_USER_OP1: word = mem[4];
      `SIG_USER_REF: word = mem[5];
      default: word = 16'hC3C3;
    endcase
  endfunction
  // serve one read at a time; data toggles outside the valid pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_q <= 1'b0;
      cnt_q <= 2'h0;
      lat_q <= 2'h0;
      addr_q <= 24'h0;
      flash_rvalid <= 1'b0;
      flash_rdata <= 16'hA5A5;
    end else begin
      flash_rvalid <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_rd && !busy_q) begin
        busy_q <= 1'b1;
        addr_q <= flash_addr;
        cnt_q <= lat_q;
        lat_q <= lat_q + 2'h1;
      end else if (busy_q && cnt_q == 2'h0) begin
        busy_q <= 1'b0;
        flash_rvalid <= 1'b1;
        flash_rdata <= word(addr_q);
      end else if (busy_q) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// [sim/tb_top.sv]
/*
  self-checking bench for the boot-mode selector: runs each strap
  pattern with random flash signatures and compares with a model.
  assumes the flash partner model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "boot_select_consts.vh"
module tb_top;
  // register byte addresses
  localparam logic [31:0] A_SYS = {14'h0, `ADDR_SYS_CONFIG};
  localparam logic [31:0] A_EXT = {14'h0, `ADDR_EXT_SELECT};
  localparam logic [31:0] A_BUS = {14'h0, `ADDR_BUS_CONFIG0};
  localparam logic [31:0] A_CTL = {14'h0, `ADDR_CONTROL};
  localparam logic [31:0] A_EMU = {14'h0, `ADDR_EMU_STATUS};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [7:0] straps = 8'hFF; // board straps
  logic ea = 1'b1; // external access pin
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic flash_rd;
  logic flash_rvalid;
  logic [23:0] flash_addr;
  logic [23:0] start_addr;
  logic [15:0] flash_rdata;
  logic wdt_req = 1'b0;
  logic ifetch = 1'b0;
  logic in_xf = 1'b0;
  logic [2:0] outcome;
  logic done, wdt_en, swr, refused, xf_en, vec0;
  integer fails = 0;
  integer n_compared = 0;
  integer seed = 32'h886B8289;
  integer fw [0:5]; // model copy of the signature words
  logic [31:0] rd; // last read data
  always #2 hclk = ~hclk;
  alternate_boot_mode_select dut_u (
    .hclk, .hresetn, .port0_low_config_pins(straps),
    .external_access_pin(ea), .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
    .hresp, .flash_rd, .flash_addr, .flash_rdata, .flash_rvalid,
    .watchdog_reset_req(wdt_req), .ifetch_req(ifetch),
    .ifetch_in_xflash(in_xf), .boot_outcome(outcome), .boot_done(done),
    .start_addr, .watchdog_enable(wdt_en), .sw_reset_req(swr),
    .fetch_refused(refused), .ext_flash_enable(xf_en),
    .vector_at_zero(vec0));
  flash_model flash_u (
    .hclk, .hresetn, .flash_rd, .flash_addr, .flash_rdata, .flash_rvalid);
  // verdict and end of run
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one comparison
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait for hready sampled high at an edge
  task wait_ready;
    integer k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      fails++;
      close_out;
    end
  endtask
  // single word transfer; read data lands in rd
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask
  // signature model: low byte of the sum complemented
  function automatic integer sig(input integer a, input integer b);
    sig = ((a + b) & 32'hFFFF) ^ 32'h00FF;
  endfunction
  // reset with one strap pattern and check the outcome
  task run_case(input logic [1:0] pat, input integer m);
    integer k;
    integer r;
    logic [2:0] eo;
    r = $random(seed);
    @(posedge hclk);
    hresetn <= 1'b0;
    straps <= {r[7:6], pat, r[3:0]};
    ea <= r[8];
    for (k = 0; k < 6; k++)
      fw[k] = $random(seed) & 32'hFFFF;
    fw[2] = sig(fw[0], fw[1]) ^ (m != 1);
    fw[5] = sig(fw[3], fw[4]) ^ (m != 2);
    for (k = 0; k < 6; k++)
      flash_u.mem[k] = fw[k][15:0];
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(posedge hclk);
      k++;
    end
    if (done !== 1'b1) begin
      fails++;
      close_out;
    end
    case (pat)
      2'b11: eo = `OUT_NORMAL;
      2'b10: eo = `OUT_STD_BOOT;
      2'b01: eo = (m == 1) ? `OUT_ALT_ALT :
        (m == 2) ? `OUT_ALT_USER : `OUT_STD_BOOT;
      default: eo = `OUT_TEST;
    endcase
    @(posedge hclk);
    chk(outcome, eo);
    chk(start_addr, eo == `OUT_ALT_ALT ? `ENTRY_ALT : 24'h0);
    chk(wdt_en, eo == `OUT_NORMAL);
    chk(vec0, 1'b1);
    ahb(1'b0, A_EMU, 32'h0);
    chk(rd[5], pat == 2'b01);
    if (pat == 2'b10) begin
      ahb(1'b0, A_SYS, 32'h0);
      chk(rd[10], 1'b1);
    end
    if (eo == `OUT_ALT_ALT || eo == `OUT_ALT_USER) begin
      ahb(1'b0, A_SYS, 32'h0);
      chk(rd, 32'h0404 | {r[7], 9'h0});
      ahb(1'b0, A_EXT, 32'h0);
      chk(rd, 32'h002D);
      ahb(1'b0, A_BUS, 32'h0);
      chk(rd, r[8] ? 32'h0 : 32'h0600 | {r[7:6], 6'h0});
    end
    straps <= ~straps;
    repeat (8) @(posedge hclk);
    chk(outcome, eo);
  endtask
  // alternate mode: watchdog, fetches, late register writes
  task alt_extras;
    integer k;
    integer e;
    @(posedge hclk);
    wdt_req <= 1'b1;
    @(posedge hclk);
    wdt_req <= 1'b0;
    e = 0;
    repeat (4) begin
      @(posedge hclk);
      if (swr === 1'b1)
        e = 1;
    end
    chk(e, 1);
    for (k = 0; k < 2; k++) begin
      @(posedge hclk);
      ifetch <= 1'b1;
      in_xf <= k[0];
      @(posedge hclk);
      ifetch <= 1'b0;
      e = 0;
      repeat (4) begin
        @(posedge hclk);
        if (refused === 1'b1)
          e = 1;
      end
      chk(e, k == 0);
    end
    ahb(1'b1, A_SYS, 32'h0400);
    repeat (3) @(posedge hclk);
    chk(xf_en, 1'b0);
    ahb(1'b1, A_EXT, 32'h0011);
    ahb(1'b1, A_SYS, 32'h0404);
    repeat (3) @(posedge hclk);
    chk(xf_en, 1'b1);
    ahb(1'b1, A_CTL, 32'h1);
    ahb(1'b1, A_EXT, 32'h0022);
    ahb(1'b0, A_EXT, 32'h0);
    chk(rd, 32'h0011);
    ahb(1'b1, A_EMU, 32'h0);
    ahb(1'b0, A_EMU, 32'h0);
    chk(rd[5], 1'b1);
    ahb(1'b0, 32'h100, 32'h0);
    chk(rd, 32'h0);
  endtask
  // main sequence
  initial begin
    run_case(2'b11, 0);
    run_case(2'b10, 1);
    run_case(2'b00, 1);
    run_case(2'b01, 1);
    alt_extras;
    run_case(2'b01, 2);
    run_case(2'b01, 0);
    close_out;
  end
endmodule
`default_nettype wire
